// [design/i2sa_consts.svh]
// constants of the i2c slave address-match block
`ifndef I2SA_CONSTS_SVH
`define I2SA_CONSTS_SVH

`define I2SA_MODE_MASTER 4'h1
`define I2SA_MODE_SLV7 4'h2
`define I2SA_MODE_SLV10 4'h3
`define I2SA_MODE_SLV7_SS 4'h4
`define I2SA_MODE_SLV10_SS 4'h5
`define I2SA_MODE_FW_MASTER 4'h6

`define I2SA_TEN_PREFIX 5'h1e
`define I2SA_GEN_CALL 8'h00
`define I2SA_SEL_7BIT 8'hfe
`define I2SA_SEL_TEN_HI 8'h06
`define I2SA_SEL_FULL 8'hff

`define I2SA_BITS_PER_BYTE 4'h8
`define I2SA_ACK_SLOT 4'h9

`define I2SA_EV_BYTE 0
`define I2SA_EV_ACK 1
`define I2SA_EV_START 2
`define I2SA_EV_STOP 3

`endif

// [design/i2sa_evt_sync.sv]
// toggle-based event crossing from the link domain to the system clock
`timescale 1ns/1ps
module i2sa_evt_sync
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic [3:0] tgl_i,
    output logic [3:0] pulse_o
);
    typedef struct packed {
        logic [3:0] s1;
        logic [3:0] s2;
        logic [3:0] s3;
    } i2sa_evt_s;

    i2sa_evt_s r;
    i2sa_evt_s next_r;

    always_comb
    begin
        next_r = r;
        next_r.s1 = tgl_i;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            r <= '0;
        else
            r <= next_r;
    end

    genvar g;
    generate
        for (g = 0; g < 4; g++)
        begin : g_lane
            assign pulse_o[g] = r.s2[g] ^ r.s3[g];
        end
    endgenerate
endmodule // i2sa_evt_sync

// [design/i2sa_pin_sync.sv]
// three-stage synchroniser with agreement filter for the bus pins
`timescale 1ns/1ps
module i2sa_pin_sync
(
    input wire logic link_clk_i,
    input wire logic reset_i,
    input wire logic [1:0] pins_i,
    output logic [1:0] filt_o
);
    typedef struct packed {
        logic [1:0] s1;
        logic [1:0] s2;
        logic [1:0] s3;
        logic [1:0] filt;
    } i2sa_pin_s;

    i2sa_pin_s r;
    i2sa_pin_s next_r;

    always_comb
    begin
        next_r = r;
        next_r.s1 = pins_i;
        next_r.s2 = r.s1;
        next_r.s3 = r.s2;
        // a level counts only once two later stages agree
        next_r.filt = (r.s2 & ~(r.s2 ^ r.s3)) | (r.filt & (r.s2 ^ r.s3));
    end

    always_ff @(posedge link_clk_i or posedge reset_i)
    begin
        if (reset_i)
            r <= '{s1: 2'h3, s2: 2'h3, s3: 2'h3, filt: 2'h3};
        else
            r <= next_r;
    end

    assign filt_o = r.filt;
endmodule // i2sa_pin_sync

// [design/i2sa_pkg.sv]
// types and decode helpers of the i2c slave address-match block
package i2sa_pkg;
`include "i2sa_consts.svh"

    typedef enum logic [2:0] {L_IDLE, L_ADDR, L_ADDR2, L_RX, L_TX, L_WAIT} i2sa_lst_e;

    typedef struct packed {
        logic en;
        logic [3:0] mode;
        logic general_call_enable;
        logic dir_in;
        logic [7:0] addr;
        logic [7:0] mask;
        logic [7:0] tx;
        logic bf;
        logic ov;
        logic ua;
    } i2sa_cfg_s;

    function automatic logic i2sa_slave_mode(input logic [3:0] m);
        return (m == `I2SA_MODE_SLV7) || (m == `I2SA_MODE_SLV10) ||
            (m == `I2SA_MODE_SLV7_SS) || (m == `I2SA_MODE_SLV10_SS);
    endfunction

    function automatic logic i2sa_ten_mode(input logic [3:0] m);
        return (m == `I2SA_MODE_SLV10) || (m == `I2SA_MODE_SLV10_SS);
    endfunction

    function automatic logic i2sa_ss_mode(input logic [3:0] m);
        return (m == `I2SA_MODE_SLV7_SS) || (m == `I2SA_MODE_SLV10_SS);
    endfunction

    // mask bit set means that address bit is a don't-care
    function automatic logic i2sa_hit(input logic [7:0] a, input logic [7:0] b,
        input logic [7:0] m, input logic [7:0] sel);
        return ((a ^ b) & ~m & sel) == 8'h00;
    endfunction
endpackage

// [design/i2sa_slave.sv]
// i2c slave address matcher: link-side bit engine and system-side flags
`timescale 1ns/1ps
module i2sa_slave
    import i2sa_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic link_clk_i,
    input wire logic port_enable_bit_i,
    input wire logic [3:0] mode_i,
    input wire logic general_call_enable_i,
    input wire logic [1:0] port_c_direction_i,
    input wire logic [7:0] addr_mask_i,
    input wire logic addr_write_i,
    input wire logic [7:0] addr_data_i,
    input wire logic buf_read_i,
    input wire logic overflow_clear_i,
    input wire logic irq_clear_i,
    input wire logic [7:0] tx_data_i,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe_o,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    output logic [7:0] receive_buffer_o,
    output logic buffer_full_flag_o,
    output logic receive_overflow_flag_o,
    output logic port_interrupt_flag_o,
    output logic update_address_flag_o,
    output logic [7:0] own_address_reg_o
);
    typedef struct packed {
        logic [7:0] rbuf;
        logic bf;
        logic ov;
        logic ua;
        logic iflag;
        logic [7:0] addr;
        i2sa_cfg_s cfg_hold;
        logic req;
        logic ack_s1;
        logic ack_s2;
    } i2sa_sys_s;

    typedef struct packed {
        logic req_s1;
        logic req_s2;
        logic req_s3;
        logic ack;
        i2sa_cfg_s cfg;
        logic scl_q;
        logic sda_q;
        i2sa_lst_e st;
        logic [7:0] sr;
        logic [3:0] cnt;
        logic ten_hi;
        logic [7:0] tx_sh;
        logic [3:0] evt;
        logic [7:0] evt_byte;
        logic evt_ok;
        logic evt_ua;
        logic pend;
        logic scl_oe;
        logic sda_oe;
    } i2sa_lnk_s;

    i2sa_sys_s s;
    i2sa_sys_s next_s;
    i2sa_lnk_s l;
    i2sa_lnk_s next_l;
    i2sa_cfg_s cfg_now;
    logic [1:0] pin_f;
    logic [3:0] ev;
    logic scl_f;
    logic sda_f;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    logic active;
    logic busy;
    logic hit;
    logic hit_ua;
    i2sa_lst_e hit_st;

    i2sa_pin_sync u_pins
    (
        .link_clk_i(link_clk_i),
        .reset_i(reset_i),
        .pins_i({sda_i, scl_i}),
        .filt_o(pin_f)
    );

    i2sa_evt_sync u_evt
    (
        .clk_i(clk_i),
        .reset_i(reset_i),
        .tgl_i(l.evt),
        .pulse_o(ev)
    );

    assign scl_f = pin_f[0];
    assign sda_f = pin_f[1];
    assign scl_rise = scl_f & ~l.scl_q;
    assign scl_fall = ~scl_f & l.scl_q;
    assign start = l.scl_q & scl_f & l.sda_q & ~sda_f;
    assign stop = l.scl_q & scl_f & ~l.sda_q & sda_f;
    assign active = l.cfg.en & l.cfg.dir_in & i2sa_slave_mode(l.cfg.mode);
    assign busy = l.cfg.bf | l.cfg.ov;

    // address decision for the byte now in the shift register
    always_comb
    begin
        hit = 1'b0;
        hit_ua = 1'b0;
        hit_st = L_WAIT;
        unique case (l.st)
            L_ADDR:
            begin
                if (l.cfg.general_call_enable && l.sr == `I2SA_GEN_CALL)
                begin
                    hit = 1'b1;
                    hit_st = L_RX;
                end
                else if (i2sa_ten_mode(l.cfg.mode))
                begin
                    if (l.sr[7:3] == `I2SA_TEN_PREFIX && i2sa_hit(l.sr, l.cfg.addr, l.cfg.mask, `I2SA_SEL_TEN_HI))
                    begin
                        if (!l.sr[0])
                        begin
                            hit = 1'b1;
                            hit_ua = 1'b1;
                            hit_st = L_ADDR2;
                        end
                        else if (l.ten_hi)
                        begin
                            hit = 1'b1;
                            hit_st = L_TX;
                        end
                    end
                end
                else if (i2sa_hit(l.sr, l.cfg.addr, l.cfg.mask, `I2SA_SEL_7BIT))
                begin
                    hit = 1'b1;
                    hit_st = l.sr[0] ? L_TX : L_RX;
                end
            end
            L_ADDR2:
            begin
                if (i2sa_hit(l.sr, l.cfg.addr, l.cfg.mask, `I2SA_SEL_FULL))
                begin
                    hit = 1'b1;
                    hit_ua = 1'b1;
                    hit_st = L_RX;
                end
            end
            L_RX:
            begin
                hit = 1'b1;
                hit_st = L_RX;
            end
            L_IDLE, L_TX, L_WAIT:
            begin
                hit = 1'b0;
            end
        endcase
    end

    // link domain: bit engine on the synchronised pins
    always_comb
    begin
        next_l = l;
        next_l.req_s1 = s.req;
        next_l.req_s2 = l.req_s1;
        next_l.req_s3 = l.req_s2;
        if (l.req_s2 != l.req_s3)
        begin
            // system side holds the word stable until this ack returns
            next_l.cfg = s.cfg_hold;
            next_l.ack = ~l.ack;
        end
        next_l.scl_q = scl_f;
        next_l.sda_q = sda_f;
        if (!active)
        begin
            next_l.st = L_IDLE;
            next_l.cnt = 4'h0;
            next_l.ten_hi = 1'b0;
            next_l.pend = 1'b0;
            next_l.sda_oe = 1'b0;
        end
        else if (start)
        begin
            next_l.st = L_ADDR;
            next_l.cnt = 4'h0;
            next_l.pend = 1'b0;
            next_l.sda_oe = 1'b0;
            next_l.evt[`I2SA_EV_START] = ~l.evt[`I2SA_EV_START];
        end
        else if (stop)
        begin
            next_l.st = L_IDLE;
            next_l.ten_hi = 1'b0;
            next_l.pend = 1'b0;
            next_l.sda_oe = 1'b0;
            next_l.evt[`I2SA_EV_STOP] = ~l.evt[`I2SA_EV_STOP];
        end
        // a refused byte still runs its ack slot so its interrupt follows
        else if (l.st == L_IDLE || (l.st == L_WAIT && !l.pend))
        begin
            next_l.sda_oe = 1'b0;
        end
        else if (scl_rise)
        begin
            if (l.cnt < `I2SA_BITS_PER_BYTE)
            begin
                if (l.st != L_TX)
                    next_l.sr = {l.sr[6:0], sda_f};
                next_l.cnt = l.cnt + 4'h1;
            end
            else if (l.cnt == `I2SA_BITS_PER_BYTE)
            begin
                next_l.cnt = `I2SA_ACK_SLOT;
                // master not acknowledging ends a read
                if (l.st == L_TX && sda_f)
                    next_l.st = L_WAIT;
            end
        end
        else if (scl_fall)
        begin
            if (l.st == L_TX && l.cnt < `I2SA_BITS_PER_BYTE)
            begin
                next_l.sda_oe = ~l.tx_sh[7];
                next_l.tx_sh = {l.tx_sh[6:0], 1'b0};
            end
            else if (l.st == L_TX && l.cnt == `I2SA_BITS_PER_BYTE)
            begin
                next_l.sda_oe = 1'b0;
            end
            else if (l.cnt == `I2SA_BITS_PER_BYTE)
            begin
                if (hit)
                begin
                    next_l.evt[`I2SA_EV_BYTE] = ~l.evt[`I2SA_EV_BYTE];
                    next_l.evt_byte = l.sr;
                    next_l.evt_ok = ~busy;
                    next_l.evt_ua = hit_ua;
                    next_l.pend = 1'b1;
                    next_l.sda_oe = ~busy;
                    next_l.st = busy ? L_WAIT : hit_st;
                    if (l.st == L_ADDR2 && !busy)
                        next_l.ten_hi = 1'b1;
                end
                else
                begin
                    next_l.st = L_WAIT;
                end
            end
            else if (l.cnt == `I2SA_ACK_SLOT)
            begin
                next_l.cnt = 4'h0;
                next_l.sda_oe = 1'b0;
                next_l.pend = 1'b0;
                if (l.pend)
                    next_l.evt[`I2SA_EV_ACK] = ~l.evt[`I2SA_EV_ACK];
                if (l.st == L_TX)
                begin
                    next_l.sda_oe = ~l.cfg.tx[7];
                    next_l.tx_sh = {l.cfg.tx[6:0], 1'b0};
                end
            end
        end
        // stretch only once the ack slot is done, or the ninth pulse never completes
        next_l.scl_oe = active & l.cfg.ua & ~scl_f & (l.cnt == 4'h0);
    end

    always_ff @(posedge link_clk_i or posedge reset_i)
    begin
        if (reset_i)
            l <= '{scl_q: 1'b1, sda_q: 1'b1, st: L_IDLE, default: '0};
        else
            l <= next_l;
    end

    // system domain: flags, buffer and own address
    always_comb
    begin
        cfg_now.en = port_enable_bit_i;
        cfg_now.mode = mode_i;
        cfg_now.general_call_enable = general_call_enable_i;
        cfg_now.dir_in = &port_c_direction_i;
        cfg_now.addr = s.addr;
        cfg_now.mask = addr_mask_i;
        cfg_now.tx = tx_data_i;
        cfg_now.bf = s.bf;
        cfg_now.ov = s.ov;
        cfg_now.ua = s.ua;
    end

    always_comb
    begin
        next_s = s;
        next_s.ack_s1 = l.ack;
        next_s.ack_s2 = s.ack_s1;
        if (s.ack_s2 == s.req && cfg_now != s.cfg_hold)
        begin
            next_s.cfg_hold = cfg_now;
            next_s.req = ~s.req;
        end
        if (addr_write_i)
        begin
            next_s.addr = addr_data_i;
            next_s.ua = 1'b0;
        end
        if (buf_read_i)
            next_s.bf = 1'b0;
        if (overflow_clear_i)
            next_s.ov = 1'b0;
        if (irq_clear_i)
            next_s.iflag = 1'b0;
        // sets follow the clears so a same-cycle event is kept
        if (ev[`I2SA_EV_BYTE])
        begin
            if (l.evt_ok)
            begin
                next_s.rbuf = l.evt_byte;
                next_s.bf = 1'b1;
                if (l.evt_ua)
                    next_s.ua = 1'b1;
            end
            else
            begin
                next_s.ov = 1'b1;
            end
        end
        if (ev[`I2SA_EV_ACK])
            next_s.iflag = 1'b1;
        if ((ev[`I2SA_EV_START] || ev[`I2SA_EV_STOP]) && i2sa_ss_mode(mode_i))
            next_s.iflag = 1'b1;
    end

    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
            s <= '0;
        else
            s <= next_s;
    end

    // open-drain: only ever pull low
    assign scl_o = 1'b0;
    assign sda_o = 1'b0;
    assign scl_oe_o = l.scl_oe;
    assign sda_oe_o = l.sda_oe;
    assign receive_buffer_o = s.rbuf;
    assign buffer_full_flag_o = s.bf;
    assign receive_overflow_flag_o = s.ov;
    assign port_interrupt_flag_o = s.iflag;
    assign update_address_flag_o = s.ua;
    assign own_address_reg_o = s.addr;

    sequence seq_decide;
        active && !start && !stop && scl_fall && l.cnt == `I2SA_BITS_PER_BYTE && hit;
    endsequence

    sequence seq_byte_ok;
        ev[`I2SA_EV_BYTE] && l.evt_ok;
    endsequence

    AST_OFF_QUIET: assert property (@(posedge link_clk_i) disable iff (reset_i)
        !active |=> !l.sda_oe && !l.scl_oe)
        else $error("pins driven while port inactive");

    AST_ACK_DRIVE: assert property (@(posedge link_clk_i) disable iff (reset_i)
        seq_decide and !busy |=> l.sda_oe && l.pend)
        else $error("accepted byte not acknowledged");

    AST_NACK_BUSY: assert property (@(posedge link_clk_i) disable iff (reset_i)
        seq_decide and busy |=> !l.sda_oe && l.st == L_WAIT)
        else $error("acknowledge given while buffer full or overflow");

    AST_GC_NO_UA: assert property (@(posedge link_clk_i) disable iff (reset_i)
        seq_decide and (l.st == L_ADDR && l.cfg.general_call_enable && l.sr == 8'h00 && !busy)
        |=> l.st == L_RX && !l.evt_ua)
        else $error("general call did not go straight to data");

    AST_START_ADDR: assert property (@(posedge link_clk_i) disable iff (reset_i)
        active && start |=> l.st == L_ADDR && l.cnt == 4'h0)
        else $error("start condition not taken");

    AST_SCL_STRETCH: assert property (@(posedge link_clk_i) disable iff (reset_i)
        active && l.cfg.ua && !scl_f && l.cnt == 4'h0 |=> l.scl_oe)
        else $error("clock not held while update-address set");

    AST_BF_SET: assert property (@(posedge clk_i) disable iff (reset_i)
        seq_byte_ok |=> s.bf && s.rbuf == $past(l.evt_byte))
        else $error("accepted byte not buffered");

    AST_REJECT_KEEPS_BUF: assert property (@(posedge clk_i) disable iff (reset_i)
        ev[`I2SA_EV_BYTE] && !l.evt_ok |=> $stable(s.rbuf) && s.ov)
        else $error("refused byte changed the buffer");

    AST_BF_CLEAR: assert property (@(posedge clk_i) disable iff (reset_i)
        buf_read_i && !ev[`I2SA_EV_BYTE] |=> !s.bf)
        else $error("buffer read did not clear buffer-full");

    AST_OV_STICKY: assert property (@(posedge clk_i) disable iff (reset_i)
        s.ov && !overflow_clear_i |=> s.ov)
        else $error("overflow cleared without software");

    AST_UA_CLEAR: assert property (@(posedge clk_i) disable iff (reset_i)
        addr_write_i && !ev[`I2SA_EV_BYTE] |=> !s.ua && s.addr == $past(addr_data_i))
        else $error("address write did not clear update-address");

    AST_SS_IRQ: assert property (@(posedge clk_i) disable iff (reset_i)
        (ev[`I2SA_EV_START] || ev[`I2SA_EV_STOP]) && i2sa_ss_mode(mode_i) |=> s.iflag)
        else $error("start or stop did not interrupt");
endmodule // i2sa_slave

// [dv/i2c_slave_address_match_test.sv]
// self-checking bench of the i2c slave address matcher
`timescale 1ns/1ps
`include "i2sa_consts.svh"
module i2c_slave_address_match_test;
    typedef struct packed {
        logic en;
        logic [3:0] mode;
        logic general_call_enable;
        logic [7:0] mask;
        logic [7:0] own;
        logic [7:0] addr;
        logic ack;
    } i2sa_row_s;
    i2sa_row_s rows [11] = '{
        '{1'b1, `I2SA_MODE_SLV7, 1'b0, 8'h00, 8'ha8, 8'ha8, 1'b1},
        '{1'b1, `I2SA_MODE_SLV7, 1'b0, 8'h00, 8'ha8, 8'haa, 1'b0},
        '{1'b1, `I2SA_MODE_SLV7, 1'b0, 8'h06, 8'ha8, 8'hae, 1'b1},
        '{1'b1, `I2SA_MODE_SLV7, 1'b1, 8'h00, 8'ha8, 8'h00, 1'b1},
        '{1'b1, `I2SA_MODE_SLV7, 1'b0, 8'h00, 8'ha8, 8'h00, 1'b0},
        '{1'b1, `I2SA_MODE_SLV7_SS, 1'b0, 8'h00, 8'ha8, 8'ha8, 1'b1},
        '{1'b1, `I2SA_MODE_SLV10, 1'b1, 8'h00, 8'hf2, 8'h00, 1'b1},
        '{1'b1, `I2SA_MODE_SLV10_SS, 1'b1, 8'h00, 8'hf2, 8'h00, 1'b1},
        '{1'b0, `I2SA_MODE_SLV7, 1'b0, 8'h00, 8'ha8, 8'ha8, 1'b0},
        '{1'b1, `I2SA_MODE_MASTER, 1'b0, 8'h00, 8'ha8, 8'ha8, 1'b0},
        '{1'b1, `I2SA_MODE_FW_MASTER, 1'b0, 8'h00, 8'ha8, 8'ha8, 1'b0}};
    logic clk_i, reset_i, link_clk, en, general_call_enable, addr_wr, buf_rd, ov_clr, irq_clr;
    logic [3:0] mode;
    logic [1:0] dir;
    logic [7:0] mask, own, tx, exp_buf, rd, buf_o, own_o;
    logic scl_oe, sda_oe, scl_o, sda_o, m_scl, m_sda, bf, ov, irq, ua, ack;
    // open-drain lines with pull-ups
    wire logic scl_ln = (scl_oe ? scl_o : 1'b1) & m_scl;
    wire logic sda_ln = (sda_oe ? sda_o : 1'b1) & m_sda;
    int err_total = 0;
    int num_checks = 0;

    i2sa_slave i_i2sa_slave (.clk_i(clk_i), .reset_i(reset_i), .link_clk_i(link_clk),
        .port_enable_bit_i(en), .mode_i(mode), .general_call_enable_i(general_call_enable),
        .port_c_direction_i(dir), .addr_mask_i(mask), .addr_write_i(addr_wr),
        .addr_data_i(own), .buf_read_i(buf_rd), .overflow_clear_i(ov_clr),
        .irq_clear_i(irq_clr), .tx_data_i(tx), .scl_i(scl_ln), .scl_o(scl_o),
        .scl_oe_o(scl_oe), .sda_i(sda_ln), .sda_o(sda_o), .sda_oe_o(sda_oe),
        .receive_buffer_o(buf_o), .buffer_full_flag_o(bf), .receive_overflow_flag_o(ov),
        .port_interrupt_flag_o(irq), .update_address_flag_o(ua), .own_address_reg_o(own_o));
    i2sa_bus_master i_i2sa_bus_master (.scl_i(scl_ln), .sda_i(sda_ln),
        .scl_rel_o(m_scl), .sda_rel_o(m_sda));

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    initial
    begin
        link_clk = 1'b0;
        #7;
        forever #62.5 link_clk = ~link_clk;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic set_addr(input logic [7:0] a);
        @(negedge clk_i);
        own = a;
        addr_wr = 1'b1;
        @(negedge clk_i);
        addr_wr = 1'b0;
    endtask
    task automatic sw(input logic rd_p, input logic irq_p, input logic ov_p);
        @(negedge clk_i);
        buf_rd = rd_p;
        irq_clr = irq_p;
        ov_clr = ov_p;
        @(negedge clk_i);
        buf_rd = 1'b0;
        irq_clr = 1'b0;
        ov_clr = 1'b0;
        @(negedge clk_i);
    endtask
    // configuration needs a handshake into the link domain before it applies
    task automatic cfg(input i2sa_row_s r);
        @(negedge clk_i);
        en = r.en;
        mode = r.mode;
        general_call_enable = r.general_call_enable;
        mask = r.mask;
        set_addr(r.own);
        #2000;
    endtask
    task automatic frame(input logic [7:0] a, input logic exp_ack);
        i_i2sa_bus_master.start();
        i_i2sa_bus_master.write_byte(a, ack);
        i_i2sa_bus_master.stop();
        repeat (10) @(negedge clk_i);
        check(8'(ack), 8'(exp_ack));
    endtask

    initial
    begin
        #1500000;
        err_total++;
        end_of_test();
    end

    initial
    begin
        {reset_i, en, general_call_enable, addr_wr, buf_rd, ov_clr, irq_clr} = 7'h40;
        {mode, mask, own, tx} = {4'h0, 8'h00, 8'h00, 8'hff};
        dir = 2'b11;
        repeat (3) @(posedge clk_i);
        @(negedge clk_i);
        reset_i = 1'b0;
        check(buf_o, 8'h00);
        check({2'h0, bf, ov, irq, ua, scl_oe, sda_oe}, 8'h00);
        $display("reset test done");
        exp_buf = 8'h00;
        foreach (rows[k])
        begin
            cfg(rows[k]);
            frame(rows[k].addr, rows[k].ack);
            if (rows[k].ack)
                exp_buf = rows[k].addr;
            check(buf_o, exp_buf);
            check({5'h00, bf, irq, ua}, {5'h00, rows[k].ack, rows[k].ack, 1'b0});
            sw(1'b1, 1'b1, 1'b1);
            $display("row %0d done", k);
        end
        // one pin left as output keeps the port off the bus
        dir = 2'b10;
        cfg('{1'b1, `I2SA_MODE_SLV7, 1'b0, 8'h00, 8'ha8, 8'h00, 1'b0});
        frame(8'ha8, 1'b0);
        check({6'h00, bf, irq}, 8'h00);
        dir = 2'b11;
        $display("direction test done");
        cfg('{1'b1, `I2SA_MODE_SLV7, 1'b0, 8'h06, 8'ha8, 8'h00, 1'b0});
        frame(8'ha8, 1'b1);
        sw(1'b0, 1'b1, 1'b0);
        frame(8'hac, 1'b0);
        check(buf_o, 8'ha8);
        check({6'h00, ov, irq}, 8'h03);
        sw(1'b1, 1'b1, 1'b0);
        check({6'h00, bf, ov}, 8'h01);
        frame(8'hac, 1'b0);
        sw(1'b0, 1'b1, 1'b1);
        check({6'h00, bf, ov}, 8'h00);
        frame(8'hac, 1'b1);
        check(buf_o, 8'hac);
        sw(1'b1, 1'b1, 1'b0);
        $display("overflow test done");
        tx = 8'h5a;
        cfg('{1'b1, `I2SA_MODE_SLV10, 1'b0, 8'h00, 8'hf2, 8'h00, 1'b0});
        i_i2sa_bus_master.start();
        i_i2sa_bus_master.write_byte(8'hf2, ack);
        repeat (10) @(negedge clk_i);
        check({4'h0, ack, bf, irq, ua}, 8'h0f);
        check(8'(scl_oe), 8'h01);
        set_addr(8'h34);
        repeat (3) @(negedge clk_i);
        check(own_o, 8'h34);
        check(8'(ua), 8'h00);
        sw(1'b1, 1'b1, 1'b0);
        i_i2sa_bus_master.write_byte(8'h34, ack);
        repeat (10) @(negedge clk_i);
        check({5'h00, ack, bf, ua}, 8'h07);
        check(buf_o, 8'h34);
        set_addr(8'hf2);
        sw(1'b1, 1'b1, 1'b0);
        i_i2sa_bus_master.start();
        i_i2sa_bus_master.write_byte(8'hf3, ack);
        repeat (10) @(negedge clk_i);
        check({5'h00, ack, bf, irq}, 8'h07);
        i_i2sa_bus_master.read_byte(1'b1, rd);
        check(rd, 8'h5a);
        i_i2sa_bus_master.stop();
        $display("ten-bit test done");
        end_of_test();
    end
endmodule // i2c_slave_address_match_test

// [dv/i2sa_bus_master.sv]
// behavioural i2c bus master with open-drain line drives
`timescale 1ns/1ps
module i2sa_bus_master
(
    input wire logic scl_i,
    input wire logic sda_i,
    output logic scl_rel_o,
    output logic sda_rel_o
);
    localparam int HALF = 1000;

    initial
    begin
        scl_rel_o = 1'b1;
        sda_rel_o = 1'b1;
    end

    // a stretched clock is waited out, but never for ever
    task automatic rel_scl();
        int n;
        scl_rel_o = 1'b1;
        n = 0;
        while (!scl_i && n < 400)
        begin
            #125;
            n++;
        end
    endtask

    // also serves as repeated start when entered with clock low
    task automatic start();
        sda_rel_o = 1'b1;
        #HALF;
        rel_scl();
        #HALF;
        sda_rel_o = 1'b0;
        #HALF;
        scl_rel_o = 1'b0;
        #(HALF / 2);
    endtask

    task automatic stop();
        sda_rel_o = 1'b0;
        #HALF;
        rel_scl();
        #HALF;
        sda_rel_o = 1'b1;
        #HALF;
    endtask

    // data moves half a phase after the fall so the slave never sees a false start
    task automatic bit_xfer(input logic b, output logic r);
        sda_rel_o = b;
        #HALF;
        rel_scl();
        #HALF;
        r = sda_i;
        scl_rel_o = 1'b0;
        #(HALF / 2);
    endtask

    task automatic write_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--)
            bit_xfer(d[i], r);
        bit_xfer(1'b1, r);
        ack = !r;
    endtask

    task automatic read_byte(input logic nack, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--)
        begin
            bit_xfer(1'b1, r);
            d[i] = r;
        end
        bit_xfer(nack, r);
    endtask
endmodule // i2sa_bus_master
